//--- src/sfp_pkg.sv
// Shared constants and types for the serial flash pin interface
package sfp_pkg;

  // Byte framing
  localparam int          SFP_BYTE_W     = 8;
  localparam logic [3:0]  SFP_BYTE_BITS  = 4'h8;
  localparam logic [7:0]  SFP_BYTE_RST   = 8'h00;

  // Receive FIFO: first-byte flag above the byte
  localparam int          SFP_FIFO_W     = 9;
  localparam int          SFP_FIFO_DEPTH = 16;
  localparam int          SFP_FIRST_BIT  = 8;

  // Synchronised pin vector positions
  localparam int          SFP_PIN_N      = 6;
  localparam int          SFP_PIN_SCK    = 0;
  localparam int          SFP_PIN_SEL    = 1;
  localparam int          SFP_PIN_L0     = 2;
  localparam int          SFP_PIN_L1     = 3;
  localparam int          SFP_PIN_L2     = 4;
  localparam int          SFP_PIN_L3     = 5;
  // Select, lanes and controls idle high, clock idles low
  localparam logic [5:0]  SFP_PIN_RST    = 6'h3e;

  // Lane output enables, active low, all released
  localparam logic [3:0]  SFP_OE_OFF     = 4'hf;

  // Bits moved per clock edge in each lane mode
  localparam logic [3:0]  SFP_W_X1       = 4'h1;
  localparam logic [3:0]  SFP_W_X2       = 4'h2;
  localparam logic [3:0]  SFP_W_X4       = 4'h4;

  typedef enum logic [1:0] {
    SFP_LANE_X1 = 2'h0,
    SFP_LANE_X2 = 2'h1,
    SFP_LANE_X4 = 2'h2
  } sfp_lane_t;

  typedef enum logic [1:0] {
    SFP_ST_UNARMED = 2'h0,
    SFP_ST_DESEL   = 2'h1,
    SFP_ST_ACTIVE  = 2'h2,
    SFP_ST_PAUSED  = 2'h3
  } sfp_state_t;

endpackage

//--- src/sfp_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sfp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (clk_en) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule

//--- src/sfp_pin_if.sv
// Device-side pin interface of a serial flash: byte link, pause, guard
`timescale 1ns/100ps
module sfp_pin_if (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Serial link pins
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        serial_in_lane0,
  output logic             serial_in_lane0_drv,
  output logic             serial_in_lane0_oe_n,
  input  wire logic        serial_out_lane1_in,
  output logic             serial_out_lane1,
  output logic             serial_out_lane1_oe_n,
  input  wire logic        write_guard_n_lane2,
  output logic             write_guard_n_lane2_drv,
  output logic             write_guard_n_lane2_oe_n,
  input  wire logic        pause_n_lane3,
  output logic             pause_n_lane3_drv,
  output logic             pause_n_lane3_oe_n,
  // Mode and configuration from the command logic
  input  wire logic [1:0]  lane_mode,
  input  wire logic        quad_cfg,
  input  wire logic        op_busy,
  // Received bytes
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_first,
  output logic             rx_overrun,
  input  wire logic        rx_overrun_clr,
  // Bytes to send
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_taken,
  // Write protection check
  input  wire logic        wr_req,
  input  wire logic        wr_in_range,
  input  wire logic [2:0]  protect_range_bits,
  output logic             wr_grant,
  output logic             wr_blocked,
  // Status
  output logic             selected,
  output logic             paused,
  output logic             standby
);

  // Pin synchroniser and filtered levels
  logic [5:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [5:0] pins;

  assign pins = {pause_n_lane3, write_guard_n_lane2, serial_out_lane1_in,
                 serial_in_lane0, sel_n, sck};

  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < sfp_pkg::SFP_PIN_N; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q  <= sfp_pkg::SFP_PIN_RST;
      s2_q  <= sfp_pkg::SFP_PIN_RST;
      s3_q  <= sfp_pkg::SFP_PIN_RST;
      flt_q <= sfp_pkg::SFP_PIN_RST;
    end else if (clk_en) begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  // Link state and shift paths
  sfp_pkg::sfp_state_t st_q, st_d;
  logic [7:0] in_sr_q, in_sr_d, out_sr_q, out_sr_d, shifted;
  logic [3:0] in_cnt_q, in_cnt_d, out_cnt_q, out_cnt_d, w;
  logic       first_q, first_d, drv_q, drv_d, taken_d;
  logic [3:0] lane_q, lane_d, oe_n_q, oe_n_d, used;
  logic       sck_rise, sck_fall, sel_fall, sel_hi, pins_func, pause_on, act;
  logic       push, fifo_ready, overrun_q, overrun_d;

  assign sck_rise = flt_d[sfp_pkg::SFP_PIN_SCK] & ~flt_q[sfp_pkg::SFP_PIN_SCK];
  assign sck_fall = ~flt_d[sfp_pkg::SFP_PIN_SCK] & flt_q[sfp_pkg::SFP_PIN_SCK];
  assign sel_fall = ~flt_d[sfp_pkg::SFP_PIN_SEL] & flt_q[sfp_pkg::SFP_PIN_SEL];
  assign sel_hi   = flt_d[sfp_pkg::SFP_PIN_SEL];

  assign pins_func = ~quad_cfg & (lane_mode != sfp_pkg::SFP_LANE_X4);
  assign pause_on  = pins_func & ~flt_d[sfp_pkg::SFP_PIN_L3] & ~sel_hi;
  assign act       = (st_q == sfp_pkg::SFP_ST_ACTIVE) & ~sel_hi & ~pause_on;

  always_comb begin
    case (lane_mode)
      sfp_pkg::SFP_LANE_X2: begin
        w    = sfp_pkg::SFP_W_X2;
        used = 4'h3;
      end
      sfp_pkg::SFP_LANE_X4: begin
        w    = sfp_pkg::SFP_W_X4;
        used = 4'hf;
      end
      default: begin
        w    = sfp_pkg::SFP_W_X1;
        used = 4'h2;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      // nothing accepted before first select fall
      sfp_pkg::SFP_ST_UNARMED: begin
        if (sel_fall) begin
          st_d = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
      sfp_pkg::SFP_ST_DESEL: begin
        if (sel_fall) begin
          st_d = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
      sfp_pkg::SFP_ST_ACTIVE: begin
        if (sel_hi) begin
          st_d = sfp_pkg::SFP_ST_DESEL;
        end else if (pause_on) begin
          st_d = sfp_pkg::SFP_ST_PAUSED;
        end
      end
      sfp_pkg::SFP_ST_PAUSED: begin
        if (sel_hi) begin
          st_d = sfp_pkg::SFP_ST_DESEL;
        end else if (!pause_on) begin
          st_d = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
      default: begin
        st_d = sfp_pkg::SFP_ST_UNARMED;
      end
    endcase
  end

  // Receive path
  always_comb begin
    in_sr_d  = in_sr_q;
    in_cnt_d = in_cnt_q;
    first_d  = first_q;
    push     = 1'b0;
    if (sel_hi) begin
      // partial byte dropped, next byte is a command
      in_cnt_d = '0;
      first_d  = 1'b1;
    end else if (act && sck_rise && !(drv_q && lane_mode != sfp_pkg::SFP_LANE_X1)) begin
      case (lane_mode)
        // lane 0 plus lane 1 inputs
        sfp_pkg::SFP_LANE_X2: in_sr_d = {in_sr_q[5:0], flt_d[sfp_pkg::SFP_PIN_L1],
                                         flt_d[sfp_pkg::SFP_PIN_L0]};
        sfp_pkg::SFP_LANE_X4: in_sr_d = {in_sr_q[3:0], flt_d[sfp_pkg::SFP_PIN_L3],
                                         flt_d[sfp_pkg::SFP_PIN_L2],
                                         flt_d[sfp_pkg::SFP_PIN_L1],
                                         flt_d[sfp_pkg::SFP_PIN_L0]};
        default:              in_sr_d = {in_sr_q[6:0], flt_d[sfp_pkg::SFP_PIN_L0]};
      endcase
      in_cnt_d = in_cnt_q + w;
      if (in_cnt_d == sfp_pkg::SFP_BYTE_BITS) begin
        push     = 1'b1;
        in_cnt_d = '0;
        first_d  = 1'b0;
      end
    end
  end

  // Drop a byte rather than stall the host; flag it sticky, set wins
  assign overrun_d = (push & ~fifo_ready) | (overrun_q & ~rx_overrun_clr);

  // Transmit path
  always_comb begin
    out_sr_d  = out_sr_q;
    out_cnt_d = out_cnt_q;
    drv_d     = drv_q;
    lane_d    = lane_q;
    taken_d   = 1'b0;
    shifted   = out_sr_q << w;
    if (sel_hi) begin
      drv_d     = 1'b0;
      out_cnt_d = '0;
    // new bits only after a falling edge
    end else if (act && sck_fall) begin
      if (out_cnt_q != '0) begin
        out_sr_d  = shifted;
        out_cnt_d = out_cnt_q - w;
      end else if (tx_valid) begin
        out_sr_d  = tx_data;
        out_cnt_d = sfp_pkg::SFP_BYTE_BITS - w;
        drv_d     = 1'b1;
        taken_d   = 1'b1;
      end else begin
        drv_d = 1'b0;
      end
      case (lane_mode)
        // dual lanes, high bit on lane 1
        sfp_pkg::SFP_LANE_X2: lane_d = {2'h0, out_sr_d[7:6]};
        sfp_pkg::SFP_LANE_X4: lane_d = out_sr_d[7:4];
        default:              lane_d = {2'h0, out_sr_d[7], 1'b0};
      endcase
    end
  end

  // release every lane unless actively sending
  assign oe_n_d = (drv_d && st_d == sfp_pkg::SFP_ST_ACTIVE) ? ~used : sfp_pkg::SFP_OE_OFF;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q      <= sfp_pkg::SFP_ST_UNARMED;
      in_sr_q   <= sfp_pkg::SFP_BYTE_RST;
      in_cnt_q  <= '0;
      first_q   <= 1'b1;
      out_sr_q  <= sfp_pkg::SFP_BYTE_RST;
      out_cnt_q <= '0;
      drv_q     <= 1'b0;
      lane_q    <= '0;
      oe_n_q    <= sfp_pkg::SFP_OE_OFF;
      tx_taken  <= 1'b0;
      overrun_q <= 1'b0;
    end else if (clk_en) begin
      st_q      <= st_d;
      in_sr_q   <= in_sr_d;
      in_cnt_q  <= in_cnt_d;
      first_q   <= first_d;
      out_sr_q  <= out_sr_d;
      out_cnt_q <= out_cnt_d;
      drv_q     <= drv_d;
      lane_q    <= lane_d;
      oe_n_q    <= oe_n_d;
      tx_taken  <= taken_d;
      overrun_q <= overrun_d;
    end
  end

  assign serial_in_lane0_drv      = lane_q[0];
  assign serial_out_lane1         = lane_q[1];
  assign write_guard_n_lane2_drv  = lane_q[2];
  assign pause_n_lane3_drv        = lane_q[3];
  assign serial_in_lane0_oe_n     = oe_n_q[0];
  assign serial_out_lane1_oe_n    = oe_n_q[1];
  assign write_guard_n_lane2_oe_n = oe_n_q[2];
  assign pause_n_lane3_oe_n       = oe_n_q[3];
  assign rx_overrun               = overrun_q;

  // Receive FIFO and registered output stage
  logic                         f_valid, f_pop;
  logic [sfp_pkg::SFP_FIFO_W-1:0] f_data;

  sfp_fifo #(
    .WIDTH (sfp_pkg::SFP_FIFO_W),
    .DEPTH (sfp_pkg::SFP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({first_q, in_sr_d}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign f_pop = f_valid & (~rx_valid | rx_ready);

  // Status and write check
  logic rxv_d, grant_d, block_d, guard_hit;

  assign rxv_d     = f_pop | (rx_valid & ~rx_ready);
  // guard works only in its control role
  assign guard_hit = pins_func & ~flt_q[sfp_pkg::SFP_PIN_L2] & wr_in_range &
                     (protect_range_bits != 3'h0);
  assign block_d   = wr_req & guard_hit;
  assign grant_d   = wr_req & ~guard_hit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_valid   <= 1'b0;
      rx_data    <= sfp_pkg::SFP_BYTE_RST;
      rx_first   <= 1'b0;
      wr_grant   <= 1'b0;
      wr_blocked <= 1'b0;
      selected   <= 1'b0;
      paused     <= 1'b0;
      standby    <= 1'b1;
    end else if (clk_en) begin
      rx_valid   <= rxv_d;
      if (f_pop) begin
        rx_data  <= f_data[7:0];
        rx_first <= f_data[sfp_pkg::SFP_FIRST_BIT];
      end
      wr_grant   <= grant_d;
      wr_blocked <= block_d;
      selected   <= (st_d == sfp_pkg::SFP_ST_ACTIVE) | (st_d == sfp_pkg::SFP_ST_PAUSED);
      paused     <= (st_d == sfp_pkg::SFP_ST_PAUSED);
      // standby needs idle array as well
      standby    <= sel_hi & ~op_busy;
    end
  end

endmodule

//--- testbench/sfp_pin_if_props.sv
// Port checks for the serial flash pin interface
`timescale 1ns/100ps
module sfp_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  // Pins and status
  input wire logic       sel_n,
  input wire logic       serial_out_lane1_oe_n,
  input wire logic       op_busy,
  input wire logic       selected,
  input wire logic       paused,
  input wire logic       standby,
  // Handshakes
  input wire logic       wr_req,
  input wire logic       wr_grant,
  input wire logic       wr_blocked,
  input wire logic       tx_taken,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data
);
  default clocking @(posedge clk); endclocking
  // Frozen cycles carry no timing
  default disable iff (sys_rst || !clk_en);
  a_desel_out_float: assert property (sel_n [*6] |-> serial_out_lane1_oe_n && !selected)
    else $error("output driven while deselected");
  a_pause_out_float: assert property (paused [*2] |-> serial_out_lane1_oe_n)
    else $error("output driven while paused");
  a_standby_idle: assert property ((sel_n && !op_busy) [*6] |-> standby)
    else $error("standby missing while idle");
  a_standby_busy: assert property (op_busy |=> !standby)
    else $error("standby while busy");
  a_write_answer: assert property (wr_req |=> wr_grant != wr_blocked)
    else $error("write request not answered once");
  a_write_quiet: assert property (!wr_req |=> !(wr_grant || wr_blocked))
    else $error("write answer without request");
  a_tx_byte_gap: assert property (tx_taken |=> !tx_taken [*8])
    else $error("send bytes loaded too close");
  a_rx_word_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data))
    else $error("receive word changed before taken");
  c_blocked: cover property (wr_blocked);
  c_paused: cover property (paused);
  c_rx_taken: cover property (rx_valid && rx_ready);
endmodule

bind sfp_pin_if sfp_props i_props (
  .clk, .sys_rst, .clk_en, .sel_n, .serial_out_lane1_oe_n, .op_busy, .selected, .paused,
  .standby, .wr_req, .wr_grant, .wr_blocked, .tx_taken, .rx_valid, .rx_ready, .rx_data
);

//--- testbench/sfp_host_model.sv
// Behavioural host controller driving the flash pins
`timescale 1ns/100ps
module sfp_host_model (
  // Clock
  input wire logic       clk,
  // Host pins, lanes 2 and 3 double as guard and pause
  output logic           sck,
  output logic           sel_n,
  output logic [3:0]     h_l,
  output logic [3:0]     h_en,
  // Resolved lane levels
  input wire logic [3:0] lanes
);
  logic mode3 = 1'b0;

  // Idle bus: clock low, deselected, pause and guard held high
  initial begin
    sck   <= 1'b0;
    sel_n <= 1'b1;
    h_l   <= 4'hf;
    h_en  <= 4'hd;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic select(input logic v);
    sel_n <= v;
    tick(8);
  endtask

  task automatic set_mode(input logic m3);
    mode3 <= m3;
    sck <= m3;
    tick(8);
  endtask

  // data set while clock low, optional stall
  task automatic xfer(input int w, input logic [7:0] b, input int n, input int st,
                      output logic [7:0] cap);
    logic [7:0] s;
    s = b;
    cap = 8'h00;
    h_en <= (w == 1) ? 4'hd : 4'hf;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      h_l <= (w == 4) ? s[7:4] : (w == 2) ? {2'h3, s[7:6]} : {3'h7, s[7]};
      tick(4);
      sck <= 1'b1;
      tick((i == st) ? 40 : 4);
      cap = {cap[6:0], lanes[1]};
      s = s << w;
    end
    if (!mode3) begin
      sck <= 1'b0;
    end
    h_l <= 4'hf;
    h_en <= 4'hd;
    tick(4);
  endtask

  // pause with select held low, clock and data wiggle
  task automatic pause_pin(input logic on);
    h_l[3] <= !on;
    tick(8);
    for (int i = 0; i < 4 && on; i++) begin
      sck <= !sck;
      h_l[0] <= !h_l[0];
      tick(4);
    end
  endtask

  task automatic guard(input logic v);
    h_l[2] <= v;
    tick(8);
  endtask

  // wide read, lanes released; mode 3 only, mode 0 lags a bit
  task automatic read_lanes(input int w, input int n, output logic [7:0] cap);
    cap = 8'h00;
    h_en <= 4'h0;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
      cap = (w == 4) ? {cap[3:0], lanes} : {cap[5:0], lanes[1:0]};
    end
    h_en <= 4'hd;
    tick(4);
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0, sys_rst, clk_en, sck, sel_n;
  logic [3:0] h_l, h_en, lanes, d_drv, d_oe_n;
  logic [1:0] lane_mode;
  logic       quad_cfg, op_busy, rx_ready, rx_overrun_clr;
  logic       tx_valid, wr_req, wr_in_range;
  logic [7:0] tx_data, rx_data, cap;
  logic [2:0] protect_range_bits;
  logic       rx_valid, rx_first, rx_overrun, tx_taken, wr_grant, wr_blocked;
  logic       selected, paused, standby;
  int         num_errors = 0, n_tests = 0, cycles = 0;
  // Guard table: guard, range bits, in range, quad, blocked
  logic [7:0] gtab [5] = '{8'h2d, 8'h6c, 8'h04, 8'h28, 8'h2e};

  always #10 clk = ~clk;
  // Pull-ups on every lane nobody drives
  assign lanes = (~d_oe_n & d_drv) | (d_oe_n & h_en & h_l) | (d_oe_n & ~h_en);

  sfp_host_model i_sfp_host_model (.clk, .sck, .sel_n, .h_l, .h_en, .lanes);
  sfp_pin_if i_sfp_pin_if (
    .clk, .sys_rst, .clk_en, .sck, .sel_n,
    .serial_in_lane0(lanes[0]), .serial_in_lane0_drv(d_drv[0]),
    .serial_in_lane0_oe_n(d_oe_n[0]), .serial_out_lane1_in(lanes[1]),
    .serial_out_lane1(d_drv[1]), .serial_out_lane1_oe_n(d_oe_n[1]),
    .write_guard_n_lane2(lanes[2]), .write_guard_n_lane2_drv(d_drv[2]),
    .write_guard_n_lane2_oe_n(d_oe_n[2]), .pause_n_lane3(lanes[3]),
    .pause_n_lane3_drv(d_drv[3]), .pause_n_lane3_oe_n(d_oe_n[3]),
    .lane_mode, .quad_cfg, .op_busy, .rx_valid, .rx_ready, .rx_data, .rx_first,
    .rx_overrun, .rx_overrun_clr, .tx_valid, .tx_data, .tx_taken, .wr_req,
    .wr_in_range, .protect_range_bits, .wr_grant, .wr_blocked, .selected, .paused, .standby
  );

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic get_rx(input logic [7:0] b, input logic f);
    int k;
    k = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk("rx byte", {f, b}, {rx_first, rx_data});
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_standby();
    op_busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk("standby", 9'h000, standby);
    op_busy <= 1'b0;
    repeat (8) @(posedge clk);
    chk("standby", 9'h001, standby);
  endtask

  // Enable low must hold every register, outputs included
  task automatic t_freeze();
    clk_en <= 1'b0;
    op_busy <= 1'b1;
    wr_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("frozen standby", 9'h001, standby);
    chk("frozen grant", 9'h000, wr_grant);
    clk_en <= 1'b1;
    wr_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("standby", 9'h000, standby);
    op_busy <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_single();
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(1, 8'ha5, 8, 3, cap);
    i_sfp_host_model.xfer(1, 8'h3c, 8, -1, cap);
    i_sfp_host_model.select(1'b1);
    get_rx(8'ha5, 1'b1);
    get_rx(8'h3c, 1'b0);
  endtask

  task automatic t_tx_mode3();
    i_sfp_host_model.set_mode(1'b1);
    tx_data <= 8'h96;
    tx_valid <= 1'b1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(1, 8'h0f, 8, -1, cap);
    i_sfp_host_model.select(1'b1);
    chk("lane1 byte", 9'h096, cap);
    chk("lane1 released", 9'h001, d_oe_n[1]);
    get_rx(8'h0f, 1'b1);
    i_sfp_host_model.set_mode(1'b0);
  endtask

  task automatic t_wide();
    lane_mode <= 2'h1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(2, 8'hc6, 4, -1, cap);
    i_sfp_host_model.select(1'b1);
    get_rx(8'hc6, 1'b1);
    lane_mode <= 2'h2;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(4, 8'h7e, 2, -1, cap);
    i_sfp_host_model.select(1'b1);
    get_rx(8'h7e, 1'b1);
    // Device drives wide lanes; mode 3 gives a fall before the first rise
    i_sfp_host_model.set_mode(1'b1);
    lane_mode <= 2'h1;
    tx_data <= 8'h2d;
    tx_valid <= 1'b1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.read_lanes(2, 4, cap);
    i_sfp_host_model.select(1'b1);
    chk("dual byte", 9'h02d, cap);
    chk("lanes released", 9'h00f, d_oe_n);
    lane_mode <= 2'h2;
    tx_data <= 8'hb4;
    tx_valid <= 1'b1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.read_lanes(4, 2, cap);
    i_sfp_host_model.select(1'b1);
    chk("quad byte", 9'h0b4, cap);
    chk("rx empty", 9'h000, rx_valid);
    i_sfp_host_model.set_mode(1'b0);
    lane_mode <= 2'h0;
  endtask

  task automatic t_partial();
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(1, 8'hff, 4, -1, cap);
    i_sfp_host_model.select(1'b1);
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(1, 8'h81, 8, -1, cap);
    i_sfp_host_model.select(1'b1);
    get_rx(8'h81, 1'b1);
    chk("rx empty", 9'h000, rx_valid);
  endtask

  task automatic t_pause();
    tx_data <= 8'h55;
    tx_valid <= 1'b1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.xfer(1, 8'ha0, 3, -1, cap);
    i_sfp_host_model.pause_pin(1'b1);
    chk("paused", 9'h001, paused);
    chk("selected", 9'h001, selected);
    chk("lane1 released", 9'h001, d_oe_n[1]);
    i_sfp_host_model.pause_pin(1'b0);
    i_sfp_host_model.xfer(1, 8'h98, 5, -1, cap);
    i_sfp_host_model.select(1'b1);
    get_rx(8'hb3, 1'b1);
    quad_cfg <= 1'b1;
    i_sfp_host_model.select(1'b0);
    i_sfp_host_model.pause_pin(1'b1);
    chk("paused", 9'h000, paused);
    i_sfp_host_model.pause_pin(1'b0);
    i_sfp_host_model.select(1'b1);
    quad_cfg <= 1'b0;
  endtask

  task automatic t_guard();
    for (int i = 0; i < 5; i++) begin
      quad_cfg <= gtab[i][1];
      wr_in_range <= gtab[i][2];
      protect_range_bits <= gtab[i][5:3];
      i_sfp_host_model.guard(gtab[i][6]);
      wr_req <= 1'b1;
      @(posedge clk);
      wr_req <= 1'b0;
      @(negedge clk);
      chk("write answer", {!gtab[i][0], gtab[i][0]}, {wr_grant, wr_blocked});
      @(posedge clk);
    end
    quad_cfg <= 1'b0;
    i_sfp_host_model.guard(1'b1);
  endtask

  task automatic t_fifo();
    i_sfp_host_model.select(1'b0);
    // Output stage holds one word beyond the FIFO depth
    for (int i = 0; i < 18; i++) begin
      i_sfp_host_model.xfer(1, 8'h40 + 8'(i), 8, -1, cap);
    end
    i_sfp_host_model.select(1'b1);
    chk("overrun", 9'h001, rx_overrun);
    for (int i = 0; i < 17; i++) begin
      get_rx(8'h40 + 8'(i), i == 0);
    end
    chk("rx empty", 9'h000, rx_valid);
    rx_overrun_clr <= 1'b1;
    @(posedge clk);
    rx_overrun_clr <= 1'b0;
    @(posedge clk);
    chk("overrun", 9'h000, rx_overrun);
  endtask

  // Send side drops its offer once the byte is loaded
  always @(posedge clk) begin
    if (tx_taken === 1'b1) begin
      tx_valid <= 1'b0;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    sys_rst            <= 1'b1;
    clk_en             <= 1'b1;
    lane_mode          <= 2'h0;
    quad_cfg           <= 1'b0;
    op_busy            <= 1'b0;
    rx_ready           <= 1'b0;
    rx_overrun_clr     <= 1'b0;
    tx_valid           <= 1'b0;
    tx_data            <= 8'h00;
    wr_req             <= 1'b0;
    wr_in_range        <= 1'b0;
    protect_range_bits <= 3'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_standby();
    t_freeze();
    t_single();
    t_tx_mode3();
    t_wide();
    t_partial();
    t_pause();
    t_guard();
    t_fifo();
    close_out();
  end
endmodule
